// ---- hdl/urxb_rx_buffer_status.sv ----
// Receive buffer, status flags and parity checking of the serial port.
`timescale 1ns/1ps

// Overview of operation
// - Data register read advances the buffer.
// - Complete flag set while unread characters exist.
// - Receiver off flushes buffer, clears complete.
// - Interrupt requested as level while complete set.
// - Error flags stored with their character.
// - Status writes leave error flags unchanged.
// - Error flags never raise interrupts.
// - Frame error equals inverted first stop bit.
// - Only first stop bit checked, regardless count.
// - Overrun on full buffer, held frame, start.
// - Overrun marks frames lost after this character.
// - Overrun cleared by successful buffer transfer.
// - Parity error zero when checking disabled.
// - Upper mode bit enables, lower selects type.
// - Checker compares data parity with parity bit.
// - Unused upper data bits read zero.
// - Receiver off discards frame, releases pin.
// - First stop bit moves frame into buffer.
module urxb_rx_buffer_status
  import urxb_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Configuration
  input wire urxb_cfg_s cfg_in,
  // Shift register side
  input wire logic start_det_in,
  input wire logic stop1_done_in,
  input wire urxb_frame_s frame_in,
  // Software side
  input wire logic data_rd_in,
  input wire logic status_wr_in,
  // Status and data
  output urxb_char_s head_out,
  output logic rx_complete_out,
  output logic rx_irq_out,
  output logic pin_override_out,
  output logic frame_busy_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    urxb_shift_e sh;
    urxb_char_s held;
    logic lost;
    urxb_char_s head;
    logic rxc;
    logic irq;
    logic ovr;
    logic busy;
  } urxb_st_s;

  urxb_st_s st_q, st_d;
  logic par_err;
  logic [8:0] data_m;
  urxb_char_s new_char;
  urxb_char_s fifo_head;
  logic fifo_wready;
  logic fifo_rvalid;
  logic push;
  logic pop;
  logic flush;
  urxb_char_s push_char;
  logic par_ref;

  urxb_parity u_parity (
    .frame_in(frame_in),
    .size_in(cfg_in.char_size_field),
    .check_on_in(cfg_in.parity_check_on),
    .odd_in(cfg_in.parity_odd_select),
    .err_out(par_err),
    .data_out(data_m)
  );

  // ****************************************
  // Character assembly
  // ****************************************
  always_comb begin
    new_char.data = data_m;
    new_char.frame_err = ~frame_in.stop1;
    new_char.parity_err = par_err;
    new_char.overrun = 1'b0;
  end

  assign flush = ~cfg_in.receiver_on;
  assign pop = data_rd_in & fifo_rvalid;
  assign push = (st_q.sh == URXB_SH_FULL);

  // A loss seen while the word waited travels with it into the buffer.
  always_comb begin
    push_char = st_q.held;
    push_char.overrun = st_q.held.overrun | st_q.lost;
  end

  // Reference parity of the frame on the lines, used by the checks.
  assign par_ref = (^data_m) ^ frame_in.parity_bit
                   ^ cfg_in.parity_odd_select;

  urxb_fifo2 #(
    .WIDTH($bits(urxb_char_s))
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .flush_in(flush),
    .wdata_in(push_char),
    .wvalid_in(push),
    .wready_out(fifo_wready),
    .rdata_out(fifo_head),
    .rvalid_out(fifo_rvalid),
    .rready_in(pop)
  );

  // ****************************************
  // Shift register holding and overrun
  // ****************************************
  // The write of status_wr_in is deliberately ignored by this logic.
  always_comb begin
    st_d = st_q;
    st_d.busy = st_q.busy;
    case (st_q.sh)
      URXB_SH_IDLE: begin
        if (start_det_in) begin
          st_d.sh = URXB_SH_RECV;
        end
      end
      URXB_SH_RECV: begin
        if (stop1_done_in) begin
          st_d.held = new_char;
          st_d.held.overrun = st_q.lost;
          st_d.sh = URXB_SH_FULL;
        end
      end
      URXB_SH_FULL: begin
        if (fifo_wready) begin
          st_d.lost = 1'b0;
          st_d.sh = start_det_in ? URXB_SH_RECV : URXB_SH_IDLE;
        end else if (start_det_in) begin
          // Buffer full and a frame waiting: the new frame is lost.
          st_d.lost = 1'b1;
        end
      end
      default: st_d.sh = URXB_SH_IDLE;
    endcase
    if (flush) begin
      st_d.sh = URXB_SH_IDLE;
      st_d.lost = 1'b0;
    end
    st_d.busy = (st_d.sh != URXB_SH_IDLE);
    // Status view updated as the buffer changes.
    st_d.head = fifo_head;
    st_d.rxc = fifo_rvalid & ~flush;
    // Only the complete flag feeds the request; error flags never do.
    st_d.irq = fifo_rvalid & ~flush & cfg_in.rx_complete_irq_on;
    st_d.ovr = st_q.lost;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    head_out = st_q.head;
    rx_complete_out = st_q.rxc;
    rx_irq_out = st_q.irq;
    frame_busy_out = st_q.busy;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_override_out <= 1'b0;
    end else begin
      pin_override_out <= cfg_in.receiver_on;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_frame_done;
    st_q.sh == URXB_SH_RECV && stop1_done_in && cfg_in.receiver_on;
  endsequence

  a_flush_clears_rxc: assert property (
    !cfg_in.receiver_on |=> ##1 !rx_complete_out)
    else $error("complete flag not cleared after flush");

  a_irq_level: assert property (
    rx_irq_out |-> rx_complete_out)
    else $error("interrupt without complete flag");

  a_irq_follows: assert property (
    fifo_rvalid && cfg_in.receiver_on && cfg_in.rx_complete_irq_on
    |=> rx_irq_out)
    else $error("interrupt dropped while complete flag set");

  a_frame_err_stop: assert property (
    s_frame_done |=> st_q.held.frame_err == !$past(frame_in.stop1))
    else $error("frame error not inverse of stop bit");

  a_parity_off: assert property (
    s_frame_done and (!cfg_in.parity_check_on)
    |=> !st_q.held.parity_err)
    else $error("parity error set while checking off");

  a_rxc_empty: assert property (
    !fifo_rvalid ##1 !fifo_rvalid |-> !rx_complete_out)
    else $error("complete flag set on empty buffer");

  a_frame_to_buf: assert property (
    s_frame_done ##1 fifo_wready && cfg_in.receiver_on |=> fifo_rvalid)
    else $error("frame not moved into buffer");

  a_overrun_set: assert property (
    st_q.sh == URXB_SH_FULL && !fifo_wready && start_det_in
    && cfg_in.receiver_on |=> st_q.lost)
    else $error("overrun not recorded");

  a_overrun_clear: assert property (
    st_q.sh == URXB_SH_FULL && fifo_wready && cfg_in.receiver_on
    |=> !st_q.lost)
    else $error("overrun not cleared on transfer");

  a_data_mask: assert property (
    s_frame_done and (cfg_in.char_size_field == URXB_CSZ_5)
    |=> st_q.held.data[8:5] == 4'h0)
    else $error("unused data bits not zero");

  sequence s_loss;
    st_q.sh == URXB_SH_FULL && !fifo_wready && start_det_in
    && cfg_in.receiver_on;
  endsequence

  sequence s_full_read;
    pop && !fifo_wready && !flush;
  endsequence

  a_status_wr_inert: assert property (
    status_wr_in && !pop && !push && !flush |=> ##1 $stable(head_out))
    else $error("status write changed the head flags");

  a_parity_calc: assert property (
    s_frame_done and (cfg_in.parity_check_on)
    |=> st_q.held.parity_err == $past(par_ref))
    else $error("parity result wrong");

  a_read_frees: assert property (
    s_full_read |=> fifo_wready)
    else $error("read did not advance the buffer");

  a_enable_gates_irq: assert property (
    !cfg_in.rx_complete_irq_on |=> !rx_irq_out)
    else $error("request raised while disabled");

  a_empty_no_irq: assert property (
    !fifo_rvalid |=> !rx_irq_out)
    else $error("request raised on empty buffer");

  a_off_idle: assert property (
    !cfg_in.receiver_on |=> !frame_busy_out)
    else $error("frame kept while receiver off");

  a_pin_on: assert property (
    cfg_in.receiver_on |=> pin_override_out)
    else $error("pin not taken while receiver on");

  a_pin_off: assert property (
    !cfg_in.receiver_on |=> !pin_override_out)
    else $error("pin not released while receiver off");

  a_head_follows: assert property (
    fifo_rvalid |=> head_out == $past(fifo_head))
    else $error("head view does not follow buffer");

  a_loss_busy: assert property (
    s_loss |=> frame_busy_out)
    else $error("waiting frame dropped on overrun");

  a_overrun_carry: assert property (
    push && st_q.lost && cfg_in.receiver_on |-> push_char.overrun)
    else $error("overrun not carried into buffer");

  a_size_nine: assert property (
    s_frame_done and (cfg_in.char_size_field == URXB_CSZ_9)
    |=> st_q.held.data == $past(frame_in.data))
    else $error("ninth data bit lost");

endmodule // urxb_rx_buffer_status

// ---- hdl/urxb_pkg.sv ----
// Package of constants and carrier types for the receive buffer block.
package urxb_pkg;

  // ****************************************
  // Character size and field positions
  // ****************************************
  localparam int URXB_DATA_W = 8;
  localparam logic [2:0] URXB_CSZ_5 = 3'h0;
  localparam logic [2:0] URXB_CSZ_6 = 3'h1;
  localparam logic [2:0] URXB_CSZ_7 = 3'h2;
  localparam logic [2:0] URXB_CSZ_8 = 3'h3;
  localparam logic [2:0] URXB_CSZ_9 = 3'h7;
  localparam int URXB_FIFO_DEPTH = 2;
  localparam logic [8:0] URXB_DATA_RST = 9'h000;

  // ****************************************
  // Carrier types
  // ****************************************
  // Frame as delivered by the receive shift register.
  typedef struct packed {
    logic [8:0] data;
    logic parity_bit;
    logic stop1;
  } urxb_frame_s;

  // Character with its flags as held in the receive buffer.
  typedef struct packed {
    logic [8:0] data;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } urxb_char_s;

  // Receiver configuration bits.
  typedef struct packed {
    logic receiver_on;
    logic rx_complete_irq_on;
    logic parity_check_on;
    logic parity_odd_select;
    logic stop_bit_count_select;
    logic [2:0] char_size_field;
  } urxb_cfg_s;

  typedef enum logic [1:0] {
    URXB_SH_IDLE,
    URXB_SH_FULL,
    URXB_SH_RECV
  } urxb_shift_e;

endpackage

// ---- hdl/urxb_parity.sv ----
// Parity checker for one received frame.
`timescale 1ns/1ps
module urxb_parity
  import urxb_pkg::*;
(
  // Frame and settings
  input wire urxb_frame_s frame_in,
  input wire logic [2:0] size_in,
  input wire logic check_on_in,
  input wire logic odd_in,
  // Result
  output logic err_out,
  output logic [8:0] data_out
);

  logic [8:0] mask;
  logic [8:0] masked;

  always_comb begin
    case (size_in)
      URXB_CSZ_5: mask = 9'h01F;
      URXB_CSZ_6: mask = 9'h03F;
      URXB_CSZ_7: mask = 9'h07F;
      URXB_CSZ_9: mask = 9'h1FF;
      default: mask = 9'h0FF;
    endcase
    masked = frame_in.data & mask;
    data_out = masked;
    // Even mode expects an even count of ones including the parity bit.
    err_out = check_on_in &
              ((^masked) ^ frame_in.parity_bit ^ odd_in);
  end

endmodule // urxb_parity

// ---- hdl/urxb_fifo2.sv ----
// Two-entry receive buffer with valid and ready on both sides.
`timescale 1ns/1ps
module urxb_fifo2
  import urxb_pkg::*;
#(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Write side
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic wvalid_in,
  output logic wready_out,
  // Read side
  output logic [WIDTH-1:0] rdata_out,
  output logic rvalid_out,
  input wire logic rready_in
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
  } urxb_fifo_st_s;

  urxb_fifo_st_s st_q, st_d;
  logic push;
  logic pop;

  always_comb begin
    st_d = st_q;
    wready_out = (st_q.count != 2'h2);
    rvalid_out = (st_q.count != 2'h0);
    rdata_out = st_q.mem[st_q.rd_ptr];
    push = wvalid_in & wready_out;
    pop = rready_in & rvalid_out;
    if (flush_in) begin
      st_d.count = 2'h0;
      st_d.rd_ptr = 1'b0;
      st_d.wr_ptr = 1'b0;
    end else begin
      if (push) begin
        st_d.mem[st_q.wr_ptr] = wdata_in;
        st_d.wr_ptr = ~st_q.wr_ptr;
      end
      if (pop) begin
        st_d.rd_ptr = ~st_q.rd_ptr;
      end
      if (push && !pop) begin
        st_d.count = st_q.count + 2'h1;
      end else if (pop && !push) begin
        st_d.count = st_q.count - 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // urxb_fifo2

// ---- sim/urxb_remote_tx.sv ----
// Model of the remote transmitter as seen through the shift register.
`timescale 1ns/1ps
module urxb_remote_tx
  import urxb_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Shift register events
  output logic start_det_out,
  output logic stop1_done_out,
  output urxb_frame_s frame_out
);
  initial begin
    start_det_out = 1'b0;
    stop1_done_out = 1'b0;
    frame_out = '1;
  end

  // A start bit alone, for a frame that never completes.
  task automatic start_only();
    @(posedge mclk_in);
    #1 start_det_out = 1'b1;
    @(posedge mclk_in);
    #1 start_det_out = 1'b0;
  endtask

  // Start, a gap of bit times, then the first stop bit with the frame.
  task automatic send(input urxb_frame_s f, input int gap);
    start_only();
    repeat (gap) @(posedge mclk_in);
    #1 frame_out = f;
    stop1_done_out = 1'b1;
    @(posedge mclk_in);
    #1 stop1_done_out = 1'b0;
    // The frame lines carry nothing valid once the stop bit has passed.
    frame_out = ~f;
  endtask
endmodule // urxb_remote_tx

// ---- sim/urxb_rx_buffer_status_tb.sv ----
// Self-checking bench for the receive buffer and status block.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module urxb_rx_buffer_status_tb
  import urxb_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  urxb_cfg_s cfg = '0;
  logic data_rd = 1'b0;
  logic status_wr = 1'b0;
  logic start_det;
  logic stop1_done;
  urxb_frame_s frame;
  urxb_char_s head;
  logic complete;
  logic irq;
  logic pin_own;
  logic busy;
  int fails = 0;
  int total_checks = 0;

  always #10 mclk_in = ~mclk_in;

  urxb_remote_tx urxb_remote_tx_inst (.mclk_in(mclk_in),
    .start_det_out(start_det), .stop1_done_out(stop1_done),
    .frame_out(frame));

  urxb_rx_buffer_status urxb_rx_buffer_status_inst (.mclk_in(mclk_in),
    .rst_in(rst_in), .cfg_in(cfg), .start_det_in(start_det),
    .stop1_done_in(stop1_done), .frame_in(frame), .data_rd_in(data_rd),
    .status_wr_in(status_wr), .head_out(head), .rx_complete_out(complete),
    .rx_irq_out(irq), .pin_override_out(pin_own), .frame_busy_out(busy));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  function automatic urxb_frame_s fr(logic [8:0] d, logic p, logic s);
    fr = {d, p, s};
  endfunction

  function automatic urxb_char_s chr(logic [8:0] d, logic [2:0] f);
    chr = {d, f};
  endfunction

  task automatic send(input logic [8:0] d, input logic p, input logic s);
    urxb_remote_tx_inst.send(fr(d, p, s), 3);
    cyc(2);
  endtask

  // Status is taken from head before the read pops it.
  task automatic rd();
    data_rd = 1'b1;
    cyc(1);
    data_rd = 1'b0;
    cyc(2);
  endtask

  // Only the status_wr strobe is pulsed; no data goes with the write.
  task automatic swr();
    status_wr = 1'b1;
    cyc(1);
    status_wr = 1'b0;
    cyc(1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_basic();
    cfg.rx_complete_irq_on = 1'b1;
    `CHK(complete, 1'b0)
    send(9'h0A5, 1'b0, 1'b1);
    `CHK(head, chr(9'h0A5, 3'h0))
    cyc(5);
    `CHK({complete, irq}, 2'h3)
    rd();
    `CHK({complete, irq}, 2'h0)
    cfg.rx_complete_irq_on = 1'b0;
  endtask

  task automatic t_overrun();
    send(9'h011, 1'b0, 1'b1);
    send(9'h022, 1'b0, 1'b1);
    `CHK(irq, 1'b0)
    send(9'h033, 1'b0, 1'b1);
    urxb_remote_tx_inst.start_only();
    cyc(2);
    `CHK(busy, 1'b1)
    swr();
    `CHK(head, chr(9'h011, 3'h0))
    rd();
    `CHK(head, chr(9'h022, 3'h0))
    rd();
    cyc(2);
    `CHK(head, chr(9'h033, 3'h2))
    swr();
    `CHK(head.overrun, 1'b1)
    rd();
    send(9'h044, 1'b0, 1'b1);
    `CHK(head, chr(9'h044, 3'h0))
    rd();
    `CHK(complete, 1'b0)
  endtask

  task automatic t_parity();
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      cfg.parity_check_on = k[2];
      cfg.parity_odd_select = k[1];
      cfg.stop_bit_count_select = k[0];
      send(9'h05A, k[0], k[1]);
      `CHK(head.parity_err, k[2] & (k[0] ^ k[1]))
      `CHK(head.frame_err, ~k[1])
      `CHK(irq, 1'b0)
      rd();
    end
    cfg.parity_check_on = 1'b0;
    send(9'h05A, 1'b0, 1'b1);
    `CHK(head.parity_err, 1'b0)
    rd();
  endtask

  task automatic t_size();
    cfg.char_size_field = URXB_CSZ_5;
    send(9'h0FF, 1'b0, 1'b1);
    `CHK(head.data, 9'h01F)
    rd();
    cfg.char_size_field = URXB_CSZ_9;
    send(9'h1A5, 1'b0, 1'b1);
    `CHK(head.data, 9'h1A5)
    rd();
    cfg.char_size_field = URXB_CSZ_8;
  endtask

  task automatic t_flush();
    send(9'h066, 1'b0, 1'b1);
    `CHK({complete, pin_own}, 2'h3)
    urxb_remote_tx_inst.start_only();
    `CHK(busy, 1'b1)
    cfg.receiver_on = 1'b0;
    cyc(2);
    `CHK(busy, 1'b0)
    `CHK(complete, 1'b0)
    `CHK(pin_own, 1'b0)
    cfg.receiver_on = 1'b1;
    cyc(3);
    `CHK({complete, pin_own}, 2'h1)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cfg.char_size_field = URXB_CSZ_8;
    cfg.receiver_on = 1'b1;
    cyc(3);
    rst_in = 1'b0;
    cyc(1);
    t_basic();
    t_overrun();
    t_parity();
    t_size();
    t_flush();
    summarize();
  end

  // Whole run needs well under 1000 cycles.
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule // urxb_rx_buffer_status_tb
